// >>> hdl/ibsl_pkg.sv
`default_nettype none
package ibsl_pkg;

    // ---------------------------------------------------------------
    // register indices and byte addresses
    // ---------------------------------------------------------------
    localparam logic [11:0] IDX_DRIVE    = 12'h10D;
    localparam logic [11:0] IDX_STATUS   = 12'h110;
    localparam logic [11:0] IDX_FUNC_SEL = 12'h120;
    localparam logic [11:0] IDX_OUT_LVL  = 12'h124;
    localparam logic [11:0] IDX_CTRL     = 12'h1FC;
    localparam logic [11:0] ADDR_DRIVE    = 12'h434;
    localparam logic [11:0] ADDR_STATUS   = 12'h440;
    localparam logic [11:0] ADDR_FUNC_SEL = 12'h480;
    localparam logic [11:0] ADDR_OUT_LVL  = 12'h490;
    localparam logic [11:0] ADDR_CTRL     = 12'h7F0;

    // ---------------------------------------------------------------
    // status word layout
    // ---------------------------------------------------------------
    localparam int BIT_GOOD      = 31;
    localparam int BIT_RESP_DONE = 30;
    localparam int BIT_EXEC_DONE = 29;
    localparam int BIT_ADDR_ERR  = 14;
    localparam int BIT_FMT_ERR   = 13;
    localparam int BIT_CODE_ERR  = 12;
    localparam int BIT_CMD_ERR   = 11;
    localparam int BIT_SIZE_ERR  = 10;
    localparam int LOC_MSB       = 6;
    localparam int CTRL_MATCH_ON = 0;

    // ---------------------------------------------------------------
    // frame check values and reset values
    // ---------------------------------------------------------------
    localparam logic [15:0] ACCESS_FORMAT = 16'h9800;
    localparam logic [15:0] ACCESS_CODE_A = 16'h0001;
    localparam logic [15:0] ACCESS_CODE_B = 16'h0002;
    localparam logic [15:0] MAX_FRAME_LEN = 16'h0140;
    localparam logic [7:0]  DRIVE_RESET   = 8'h62;
    localparam logic [9:0]  PIN_RESET     = 10'h000;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // register select decoded from an address
    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_DRIVE,
        SEL_STATUS,
        SEL_FUNC,
        SEL_LEVEL,
        SEL_CTRL
    } ibsl_sel_e;

endpackage
`default_nettype wire

// >>> hdl/ibsl_regs.sv
`timescale 1ns/1ps
`default_nettype none
module ibsl_regs #(
    parameter int PINS = 10
) (
    // clock, reset, enable
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              ce,
    // axi4-lite write address and data
    input  wire logic [11:0]       awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    // axi4-lite write response
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // axi4-lite read
    input  wire logic [11:0]       araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // frame engine header check
    input  wire logic              hdrValid,
    input  wire logic              tagMatch,
    input  wire logic [47:0]       destMac,
    input  wire logic [47:0]       switchMac,
    input  wire logic [15:0]       accessFormat,
    input  wire logic [15:0]       accessCode,
    input  wire logic [15:0]       frameLen,
    // frame engine events
    input  wire logic              cmdBad,
    input  wire logic [6:0]        cmdLoc,
    input  wire logic              respDone,
    input  wire logic              execDone,
    // frame engine verdicts
    output logic                   frameDiscard,
    output logic                   respSuppress,
    output logic                   inbandDestMatchOn,
    // pins
    input  wire logic [PINS-1:0]   linkInd,
    output logic [PINS-1:0]        indicatorPin,
    output logic [7:0]             padDrive
);

    // ---------------------------------------------------------------
    // assertion defaults
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // address decode shared by read and write
    function automatic ibsl_pkg::ibsl_sel_e decodeSel(input logic [11:0] a);
        case (a)
            ibsl_pkg::ADDR_DRIVE:    decodeSel = ibsl_pkg::SEL_DRIVE;
            ibsl_pkg::ADDR_STATUS:   decodeSel = ibsl_pkg::SEL_STATUS;
            ibsl_pkg::ADDR_FUNC_SEL: decodeSel = ibsl_pkg::SEL_FUNC;
            ibsl_pkg::ADDR_OUT_LVL:  decodeSel = ibsl_pkg::SEL_LEVEL;
            ibsl_pkg::ADDR_CTRL:     decodeSel = ibsl_pkg::SEL_CTRL;
            default:                 decodeSel = ibsl_pkg::SEL_NONE;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // write channel
    // ---------------------------------------------------------------
    logic        awHeld_q;
    logic        wHeld_q;
    logic [11:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0]  wStrb_q;
    logic        awready_q;
    logic        wready_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        doWrite;
    logic        awHeld_d;
    logic        wHeld_d;
    logic        bvalid_d;
    ibsl_pkg::ibsl_sel_e wSel;

    // next values of the write handshake
    assign doWrite  = awHeld_q & wHeld_q & ~bvalid_q;
    assign awHeld_d = (awHeld_q | (awvalid & awready_q)) & ~doWrite;
    assign wHeld_d  = (wHeld_q | (wvalid & wready_q)) & ~doWrite;
    assign bvalid_d = doWrite | (bvalid_q & ~bready);
    assign wSel     = decodeSel(awAddr_q);

    // address and data taken in either order
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            awHeld_q  <= 1'b0;
            wHeld_q   <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= ibsl_pkg::RESP_OKAY;
            awAddr_q  <= 12'h000;
            wData_q   <= 32'h0000_0000;
            wStrb_q   <= 4'h0;
        end else if (ce) begin
            awHeld_q  <= awHeld_d;
            wHeld_q   <= wHeld_d;
            awready_q <= ~awHeld_d & ~bvalid_d;
            wready_q  <= ~wHeld_d & ~bvalid_d;
            bvalid_q  <= bvalid_d;
            if (awvalid & awready_q) begin
                awAddr_q <= awaddr;
            end
            if (wvalid & wready_q) begin
                wData_q <= wdata;
                wStrb_q <= wstrb;
            end
            if (doWrite) begin
                bresp_q <= (wSel == ibsl_pkg::SEL_NONE) ?
                           ibsl_pkg::RESP_SLVERR : ibsl_pkg::RESP_OKAY;
            end
        end
    end

    // ---------------------------------------------------------------
    // writable registers
    // ---------------------------------------------------------------
    logic [PINS-1:0] funcSel_q;
    logic [PINS-1:0] outLevel_q;
    logic [7:0]      drive_q;
    logic            matchOn_q;
    logic [31:0]     funcNew, levelNew, driveNew, ctrlNew;

    // byte strobes merged with old word per target
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        merge = r;
    endfunction

    // merged word per target, sliced below
    assign funcNew  = merge(32'(funcSel_q), wData_q, wStrb_q);
    assign levelNew = merge(32'(outLevel_q), wData_q, wStrb_q);
    assign driveNew = merge(32'(drive_q), wData_q, wStrb_q);
    assign ctrlNew  = merge(32'(matchOn_q), wData_q, wStrb_q);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            funcSel_q  <= PINS'(ibsl_pkg::PIN_RESET);
            outLevel_q <= PINS'(ibsl_pkg::PIN_RESET);
            drive_q    <= ibsl_pkg::DRIVE_RESET;
            matchOn_q  <= 1'b0;
        end else if (ce && doWrite) begin
            case (wSel)
                ibsl_pkg::SEL_FUNC:  funcSel_q  <= funcNew[PINS-1:0];
                ibsl_pkg::SEL_LEVEL: outLevel_q <= levelNew[PINS-1:0];
                ibsl_pkg::SEL_DRIVE: drive_q    <= driveNew[7:0];
                ibsl_pkg::SEL_CTRL:
                    matchOn_q <= ctrlNew[ibsl_pkg::CTRL_MATCH_ON];
                default: ;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // in-band status flags
    // ---------------------------------------------------------------
    logic       good_q;
    logic       respDone_q;
    logic       execDone_q;
    logic       addrErr_q;
    logic       fmtErr_q;
    logic       codeErr_q;
    logic       cmdErr_q;
    logic       sizeErr_q;
    logic [6:0] loc_q;
    logic       clrFlags;
    logic       badAddr;
    logic       badFmt;
    logic       badCode;
    logic       badSize;

    assign badAddr  = matchOn_q & (destMac != switchMac);
    assign badFmt   = accessFormat != ibsl_pkg::ACCESS_FORMAT;
    assign badCode  = (accessCode != ibsl_pkg::ACCESS_CODE_A) &&
                      (accessCode != ibsl_pkg::ACCESS_CODE_B);
    assign badSize  = frameLen > ibsl_pkg::MAX_FRAME_LEN;
    assign clrFlags = hdrValid & tagMatch;

    // sticky flags, a set beats a clear in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            good_q     <= 1'b0;
            respDone_q <= 1'b0;
            execDone_q <= 1'b0;
            addrErr_q  <= 1'b0;
            fmtErr_q   <= 1'b0;
            codeErr_q  <= 1'b0;
            cmdErr_q   <= 1'b0;
            sizeErr_q  <= 1'b0;
            loc_q      <= 7'h00;
        end else if (ce) begin
            good_q     <= good_q | (hdrValid & ~(badAddr | badFmt |
                                               badCode | badSize));
            respDone_q <= (respDone_q & ~clrFlags) | respDone;
            execDone_q <= (execDone_q & ~clrFlags) | execDone;
            addrErr_q  <= (addrErr_q & ~clrFlags) | (hdrValid & badAddr);
            fmtErr_q   <= (fmtErr_q & ~clrFlags) | (hdrValid & badFmt);
            codeErr_q  <= (codeErr_q & ~clrFlags) | (hdrValid & badCode);
            cmdErr_q   <= (cmdErr_q & ~clrFlags) | cmdBad;
            sizeErr_q  <= (sizeErr_q & ~clrFlags) | (hdrValid & badSize);
            if (cmdBad) begin
                loc_q <= cmdLoc;
            end else if (clrFlags) begin
                loc_q <= 7'h00;
            end
        end
    end

    // verdict pulses back to the frame engine
    logic frameDiscard_q;
    logic respSuppress_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frameDiscard_q <= 1'b0;
            respSuppress_q <= 1'b0;
        end else if (ce) begin
            frameDiscard_q <= hdrValid & badAddr;
            respSuppress_q <= hdrValid & badSize;
        end
    end

    // ---------------------------------------------------------------
    // read channel
    // ---------------------------------------------------------------
    logic        arready_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic        rvalid_d;
    logic [31:0] statusWord;
    logic [31:0] rdMux;
    ibsl_pkg::ibsl_sel_e rSel;

    assign rvalid_d = (arvalid & arready_q) | (rvalid_q & ~rready);
    assign rSel     = decodeSel(araddr);

    always_comb begin
        statusWord = 32'h0000_0000;
        statusWord[ibsl_pkg::BIT_GOOD]      = good_q;
        statusWord[ibsl_pkg::BIT_RESP_DONE] = respDone_q;
        statusWord[ibsl_pkg::BIT_EXEC_DONE] = execDone_q;
        statusWord[ibsl_pkg::BIT_ADDR_ERR]  = addrErr_q;
        statusWord[ibsl_pkg::BIT_FMT_ERR]   = fmtErr_q;
        statusWord[ibsl_pkg::BIT_CODE_ERR]  = codeErr_q;
        statusWord[ibsl_pkg::BIT_CMD_ERR]   = cmdErr_q;
        statusWord[ibsl_pkg::BIT_SIZE_ERR]  = sizeErr_q;
        statusWord[ibsl_pkg::LOC_MSB:0]     = loc_q;
    end

    // read data select
    always_comb begin
        case (rSel)
            ibsl_pkg::SEL_DRIVE:  rdMux = 32'(drive_q);
            ibsl_pkg::SEL_STATUS: rdMux = statusWord;
            ibsl_pkg::SEL_FUNC:   rdMux = 32'(funcSel_q);
            ibsl_pkg::SEL_LEVEL:  rdMux = 32'(outLevel_q);
            ibsl_pkg::SEL_CTRL:   rdMux = 32'(matchOn_q);
            default:              rdMux = 32'h0000_0000;
        endcase
    end

    // one read in flight, answer one cycle after address
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= ibsl_pkg::RESP_OKAY;
        end else if (ce) begin
            arready_q <= ~rvalid_d;
            rvalid_q  <= rvalid_d;
            if (arvalid & arready_q) begin
                rdata_q <= rdMux;
                rresp_q <= (rSel == ibsl_pkg::SEL_NONE) ?
                           ibsl_pkg::RESP_SLVERR : ibsl_pkg::RESP_OKAY;
            end
        end
    end

    // ---------------------------------------------------------------
    // indicator pins
    // ---------------------------------------------------------------
    logic [PINS-1:0] pin_q;
    for (genvar i = 0; i < PINS; i++) begin : g_pin
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                pin_q[i] <= 1'b0;
            end else if (ce) begin
                pin_q[i] <= funcSel_q[i] ? outLevel_q[i] : linkInd[i];
            end
        end
    end

    // outputs straight from flops
    assign awready           = awready_q;
    assign wready            = wready_q;
    assign bvalid            = bvalid_q;
    assign bresp             = bresp_q;
    assign arready           = arready_q;
    assign rvalid            = rvalid_q;
    assign rdata             = rdata_q;
    assign rresp             = rresp_q;
    assign frameDiscard      = frameDiscard_q;
    assign respSuppress      = respSuppress_q;
    assign inbandDestMatchOn = matchOn_q;
    assign indicatorPin      = pin_q;
    assign padDrive          = drive_q;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence hdrSeen;
        ce && hdrValid;
    endsequence

    chk_good_flag: assert property (
        hdrSeen ##0 (!badAddr && !badFmt && !badCode && !badSize)
        |=> good_q)
        else $error("good frame flag not set");

    chk_resp_set: assert property (
        ce && respDone |=> respDone_q)
        else $error("response flag lost");

    chk_tag_clear: assert property (
        hdrSeen ##0 tagMatch && !execDone |=> !execDone_q)
        else $error("tag match did not clear");

    chk_fmt_error: assert property (
        hdrSeen ##0 (accessFormat != 16'h9800) |=> fmtErr_q)
        else $error("format error missed");

    chk_code_error: assert property (
        hdrSeen ##0 (accessCode == 16'h0001) && !tagMatch
        |=> codeErr_q == $past(codeErr_q))
        else $error("valid code flagged");

    chk_size_drop: assert property (
        hdrSeen ##0 (frameLen > 16'd320) |=> respSuppress_q && sizeErr_q)
        else $error("oversize not handled");

    chk_cmd_loc: assert property (
        ce && cmdBad |=> cmdErr_q && loc_q == $past(cmdLoc))
        else $error("command location wrong");

    chk_pin_mux: assert property (
        ce |=> pin_q == (($past(funcSel_q) & $past(outLevel_q)) |
                         (~$past(funcSel_q) & $past(linkInd))))
        else $error("pin level wrong");

    chk_discard: assert property (
        hdrSeen ##0 matchOn_q && (destMac != switchMac)
        |=> frameDiscard_q ##0 addrErr_q)
        else $error("mismatch not discarded");

    sequence bothHeld;
        ce && awHeld_q && wHeld_q && !bvalid_q;
    endsequence

    chk_write_resp: assert property (
        bothHeld |=> bvalid_q ##0 !awready_q && !wready_q)
        else $error("write response missing");

    chk_read_resp: assert property (
        ce && arvalid && arready_q |=> rvalid_q && !arready_q)
        else $error("read response late");

endmodule // ibsl_regs
`default_nettype wire

// >>> verif/tb_inband_status_led_gpo_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_inband_status_led_gpo_regs;
    // ---------------------------------------------------------------
    // stimulus, observed outputs and model state
    // ---------------------------------------------------------------
    logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [3:0]  wstrb = 4'hF;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic        hdrValid = 1'b0, tagMatch = 1'b0, cmdBad = 1'b0;
    logic        respDone = 1'b0, execDone = 1'b0;
    logic [47:0] destMac = 48'h0, switchMac = 48'h0A0B_0C0D_0E0F;
    logic [15:0] accessFormat = 16'h0, accessCode = 16'h0, frameLen = 16'h0;
    logic [6:0]  cmdLoc = 7'h00;
    logic        frameDiscard, respSuppress, inbandDestMatchOn;
    logic [9:0]  linkInd = 10'h2A5, indicatorPin;
    logic [7:0]  padDrive;
    logic [31:0] seed = 32'hAFA4_D99D, statM = 32'h0, selM = 32'h0;
    logic [31:0] lvlM = 32'h0, d;
    logic        ctrlM = 1'b0;
    int          nMismatch = 0, nChecks = 0;

    ibsl_regs #(.PINS(10)) u_dut (
        .clk(clk), .rst_n(rst_n), .ce(ce),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .hdrValid(hdrValid), .tagMatch(tagMatch), .destMac(destMac),
        .switchMac(switchMac), .accessFormat(accessFormat),
        .accessCode(accessCode), .frameLen(frameLen), .cmdBad(cmdBad),
        .cmdLoc(cmdLoc), .respDone(respDone), .execDone(execDone),
        .frameDiscard(frameDiscard), .respSuppress(respSuppress),
        .inbandDestMatchOn(inbandDestMatchOn), .linkInd(linkInd),
        .indicatorPin(indicatorPin), .padDrive(padDrive)
    );

    // free-running 100 MHz clock
    always #5 clk = ~clk;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // byte-lane merge of a write into a model register
    function automatic logic [31:0] merge(logic [31:0] o, n, logic [3:0] s);
        logic [31:0] m;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        return (o & ~m) | (n & m);
    endfunction

    task automatic chk(input string what, input logic [31:0] seen, exp);
        nChecks++;
        if (seen !== exp) begin
            nMismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", nChecks, nMismatch);
        if (nMismatch == 0 && nChecks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // axi4-lite write, address and data offered together
    task automatic wr(input logic [11:0] a, input logic [31:0] v,
                      input logic [3:0] s, input logic [1:0] er);
        bit aw, w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk);
            if (!aw && awready) begin
                aw = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w && wready) begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (!bvalid);
        bready <= 1'b0;
        chk("bresp", {30'h0, bresp}, {30'h0, er});
    endtask

    // axi4-lite read with expected data and response
    task automatic rd(input logic [11:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        rready <= 1'b0;
        chk("rdata", rdata, e);
        chk("rresp", {30'h0, rresp}, {30'h0, er});
    endtask

    // one header check pulse, then verdicts and status
    task automatic frame(input bit tag, input logic [15:0] fmt, code, len,
                         input bit same);
        logic [31:0] e;
        e = 32'h0;
        @(posedge clk);
        hdrValid <= 1'b1;
        tagMatch <= tag;
        accessFormat <= fmt;
        accessCode <= code;
        frameLen <= len;
        destMac <= same ? switchMac : switchMac ^ {rnd(), 16'h0001};
        @(posedge clk);
        hdrValid <= 1'b0;
        #1;
        if (ctrlM && !same) e[ibsl_pkg::BIT_ADDR_ERR] = 1'b1;
        if (fmt != 16'h9800) e[ibsl_pkg::BIT_FMT_ERR] = 1'b1;
        if (code != 16'h0001 && code != 16'h0002)
            e[ibsl_pkg::BIT_CODE_ERR] = 1'b1;
        if (len > 16'h0140) e[ibsl_pkg::BIT_SIZE_ERR] = 1'b1;
        if (tag) statM = statM & ~32'h6000_7C7F;
        statM = statM | e;
        if (e == 32'h0) statM[ibsl_pkg::BIT_GOOD] = 1'b1;
        chk("discard", {31'h0, frameDiscard}, {31'h0, ctrlM && !same});
        chk("suppress", {31'h0, respSuppress}, {31'h0, len > 16'h0140});
        rd(ibsl_pkg::ADDR_STATUS, statM, ibsl_pkg::RESP_OKAY);
    endtask

    // engine event pulse: 0 response sent, 1 exec done, 2 bad command
    task automatic evt(input int k, input logic [6:0] loc);
        @(posedge clk);
        respDone <= (k == 0);
        execDone <= (k == 1);
        cmdBad <= (k == 2);
        cmdLoc <= loc;
        @(posedge clk);
        respDone <= 1'b0;
        execDone <= 1'b0;
        cmdBad <= 1'b0;
        if (k == 0) statM[ibsl_pkg::BIT_RESP_DONE] = 1'b1;
        if (k == 1) statM[ibsl_pkg::BIT_EXEC_DONE] = 1'b1;
        if (k == 2) statM = {statM[31:12], 1'b1, statM[10:7], loc};
        rd(ibsl_pkg::ADDR_STATUS, statM, ibsl_pkg::RESP_OKAY);
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk("pins", {22'h0, indicatorPin}, {22'h0, linkInd});
        rd(ibsl_pkg::ADDR_STATUS, 32'h0, ibsl_pkg::RESP_OKAY);
        rd(ibsl_pkg::ADDR_FUNC_SEL, 32'h0, ibsl_pkg::RESP_OKAY);
        rd(ibsl_pkg::ADDR_OUT_LVL, 32'h0, ibsl_pkg::RESP_OKAY);
        rd(ibsl_pkg::ADDR_DRIVE, 32'h62, ibsl_pkg::RESP_OKAY);
        rd(ibsl_pkg::ADDR_CTRL, 32'h0, ibsl_pkg::RESP_OKAY);
        rd(12'h444, 32'h0, ibsl_pkg::RESP_SLVERR);
        wr(12'h444, 32'hFFFF_FFFF, 4'hF, ibsl_pkg::RESP_SLVERR);
        $display("test reset and map done");
        for (int i = 0; i < 10; i++) begin
            d = rnd();
            wr(ibsl_pkg::ADDR_FUNC_SEL, d, d[3:0] | 4'h1, ibsl_pkg::RESP_OKAY);
            selM = merge(selM, d, d[3:0] | 4'h1) & 32'h0000_03FF;
            d = rnd();
            wr(ibsl_pkg::ADDR_OUT_LVL, d, 4'hF, ibsl_pkg::RESP_OKAY);
            lvlM = d & 32'h0000_03FF;
            rd(ibsl_pkg::ADDR_FUNC_SEL, selM, ibsl_pkg::RESP_OKAY);
            rd(ibsl_pkg::ADDR_OUT_LVL, lvlM, ibsl_pkg::RESP_OKAY);
            d = rnd();
            @(posedge clk);
            linkInd <= d[9:0];
            @(posedge clk);
            #1;
            chk("pins", {22'h0, indicatorPin}, (selM & lvlM) | (~selM & {22'h0, d[9:0]}));
        end
        d = rnd();
        wr(ibsl_pkg::ADDR_DRIVE, d, 4'hF, ibsl_pkg::RESP_OKAY);
        rd(ibsl_pkg::ADDR_DRIVE, {24'h0, d[7:0]}, ibsl_pkg::RESP_OKAY);
        chk("padDrive", {24'h0, padDrive}, {24'h0, d[7:0]});
        $display("test pins done");
        frame(1'b0, 16'h9800, 16'h0001, 16'h0040, 1'b0);
        evt(0, 7'h00);
        evt(1, 7'h00);
        evt(2, 7'h5B);
        frame(1'b0, 16'h9801, 16'h0003, 16'h0141, 1'b0);
        frame(1'b1, 16'h9800, 16'h0000, 16'h0140, 1'b1);
        wr(ibsl_pkg::ADDR_CTRL, 32'h0000_0001, 4'hF, ibsl_pkg::RESP_OKAY);
        ctrlM = 1'b1;
        chk("matchOn", {31'h0, inbandDestMatchOn}, 32'h1);
        frame(1'b0, 16'h9800, 16'h0002, 16'h0140, 1'b0);
        evt(2, 7'h7F);
        frame(1'b1, 16'h9800, 16'h0002, 16'h0020, 1'b1);
        wr(ibsl_pkg::ADDR_STATUS, 32'hFFFF_FFFF, 4'hF, ibsl_pkg::RESP_OKAY);
        rd(ibsl_pkg::ADDR_STATUS, statM, ibsl_pkg::RESP_OKAY);
        $display("test status done");
        // clock enable low: events and pin changes are frozen
        d = (selM & lvlM) | (~selM & {22'h0, linkInd});
        @(posedge clk);
        ce <= 1'b0;
        respDone <= 1'b1;
        linkInd <= ~linkInd;
        repeat (2) @(posedge clk);
        #1;
        chk("frozen pins", {22'h0, indicatorPin}, d);
        @(posedge clk);
        ce <= 1'b1;
        respDone <= 1'b0;
        rd(ibsl_pkg::ADDR_STATUS, statM, ibsl_pkg::RESP_OKAY);
        d = (selM & lvlM) | (~selM & {22'h0, linkInd});
        chk("pins", {22'h0, indicatorPin}, d);
        $display("test enable done");
        // second reset in mid-run brings back defaults
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        statM = 32'h0;
        selM = 32'h0;
        lvlM = 32'h0;
        ctrlM = 1'b0;
        repeat (2) @(posedge clk);
        chk("pins", {22'h0, indicatorPin}, {22'h0, linkInd});
        rd(ibsl_pkg::ADDR_STATUS, statM, ibsl_pkg::RESP_OKAY);
        rd(ibsl_pkg::ADDR_FUNC_SEL, selM, ibsl_pkg::RESP_OKAY);
        rd(ibsl_pkg::ADDR_OUT_LVL, lvlM, ibsl_pkg::RESP_OKAY);
        rd(ibsl_pkg::ADDR_DRIVE, 32'h62, ibsl_pkg::RESP_OKAY);
        rd(ibsl_pkg::ADDR_CTRL, 32'h0, ibsl_pkg::RESP_OKAY);
        $display("test second reset done");
        summarize();
    end

    // watchdog: the whole run needs a few hundred cycles
    initial begin
        #200000;
        nMismatch++;
        $display("watchdog expired");
        summarize();
    end
endmodule // tb_inband_status_led_gpo_regs
`default_nettype wire
